// File: supervisor_pkg.sv
// constants and behaviour list for the supply reset supervisor
// Behaviour
// [R01] from about 1 V supply upward, both resets are held asserted
// [R02] supply rising above trip level starts the hold timer, resets stay asserted
// [R03] on expiry both resets release together
// [R04] supply below trip level minus hysteresis asserts both resets
// [R05] supply dropping during hold keeps reset; full delay restarts on next rise
// [R06] external driver holds manual reset low at least 500 ns or 150 ns
// [R07] resets assert within 250 ns of a valid manual low pulse at 5 V
// [R08] manual reset release starts the hold timer, release after about 200 ms
// [R09] on power-down resets stay asserted until supply is below 1 V
// [R10] two reset outputs of opposite polarity, both actively driven
// [R11] manual reset is active low; hold delay debounces a pushbutton
// [R12] an unused manual reset input is tied high or left to read inactive
// [R13] power-fail output is high above the reference, low below it
// [R14] power-fail comparison has hysteresis so the output does not chatter
// [R15] host may use power-fail output as an interrupt for orderly shutdown
// [R16] below 1 V the active-low reset output becomes undriven
// [R17] hold delay lies between 140 and 280 ms, typically 200 ms
// [R18] near 3 V, resets assert within 750 ns of a valid manual low pulse
// [R19] comparisons arrive as digital inputs; delay is a counter cleared by any source
// [R20] any active source forces reset; release only after count completes, sources idle
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned HOLD_MS = 200;
  localparam int unsigned HOLD_MIN_MS = 140;
  localparam int unsigned HOLD_MAX_MS = 280;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned MAN_DELAY_NS = 250;
  localparam int unsigned MAN_DELAY_CYC = MAN_DELAY_NS / CLK_NS;
  localparam int unsigned CNT_W = 23;
  localparam logic RST_N_ASSERTED = 1'b0;
  localparam logic RST_H_ASSERTED = 1'b1;
  localparam logic WARN_RESET = 1'b0;
endpackage : supervisor_pkg

// File: supply_reset_supervisor.sv
// reset sequencing logic of the supply supervisor
`timescale 1ns/10ps
module supply_reset_supervisor #(
  parameter int unsigned HOLD_CYCLES = supervisor_pkg::HOLD_CYC // hold delay in clocks
) (
  input wire logic mclk_i,                  // 20 MHz time base
  input wire logic sys_rst_i,               // sync reset, active high
  input wire logic supply_ok_i,             // digitised supply above trip level
  input wire logic supply_live_i,           // supply above 1 V, output stage powered
  input wire logic manual_reset_n_in_i,     // manual reset, active low
  input wire logic power_fail_sense_in_i,   // digitised sense-above-reference
  output logic reset_n_o,                   // active-low reset level
  output logic reset_n_oe_o,                // active-low reset driver enable
  output logic reset_o,                     // active-high reset
  output logic power_fail_warn_out_o        // power-fail warning, low when sense low
);
  import supervisor_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // three-stage input capture; change accepted once stages two and three agree
  logic [2:0] sup_sync_r, man_sync_r, pf_sync_r, live_sync_r;
  logic sup_ok_r, man_n_r, pf_r, live_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sup_sync_r <= 3'h0;
      man_sync_r <= 3'h7;
      pf_sync_r <= 3'h0;
      live_sync_r <= 3'h0;
    end else begin
      sup_sync_r <= {sup_sync_r[1:0], supply_ok_i};
      man_sync_r <= {man_sync_r[1:0], manual_reset_n_in_i};
      pf_sync_r <= {pf_sync_r[1:0], power_fail_sense_in_i};
      live_sync_r <= {live_sync_r[1:0], supply_live_i};
    end
  end

  // stages two and three must match before a change is taken
  function automatic logic agree_f(input logic [2:0] stages);
    return stages[1] == stages[2];
  endfunction : agree_f

  wire sup_agree = agree_f(sup_sync_r);
  wire man_agree = agree_f(man_sync_r);
  wire pf_agree = agree_f(pf_sync_r);
  wire live_agree = agree_f(live_sync_r);

  // reset-time values: supply treated low so power-up starts asserted
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sup_ok_r <= 1'b0;
      man_n_r <= 1'b1;
      pf_r <= WARN_RESET;
      live_r <= 1'b0;
    end else begin
      if (sup_agree) sup_ok_r <= sup_sync_r[2]; // R04
      if (man_agree) man_n_r <= man_sync_r[2];  // R11
      // analog hysteresis sits ahead; the agree filter adds chatter immunity
      if (pf_agree) pf_r <= pf_sync_r[2];       // R14
      if (live_agree) live_r <= live_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hold timer: cleared while any source active, counts up once all idle
  logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
  wire src_active = !sup_ok_r || !man_n_r; // R20
  wire hold_done = hold_cnt_r >= CNT_W'(HOLD_CYCLES); // R17
  wire assert_nxt = src_active || !hold_done; // R02 R05 R08

  assign hold_cnt_nxt = src_active ? '0 : // R19 R05
                        (hold_done ? hold_cnt_r : hold_cnt_r + 1'b1);

  logic asserted_r;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hold_cnt_r <= '0;
      asserted_r <= 1'b1; // R01
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
      asserted_r <= assert_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops; both polarities switch in the same edge
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reset_n_o <= RST_N_ASSERTED;   // R01 R09
      reset_o <= RST_H_ASSERTED;
      reset_n_oe_o <= 1'b0;
      power_fail_warn_out_o <= WARN_RESET;
    end else begin
      reset_n_o <= assert_nxt ? RST_N_ASSERTED : !RST_N_ASSERTED; // R03 R10
      reset_o <= assert_nxt ? RST_H_ASSERTED : !RST_H_ASSERTED;   // R03 R10
      // below 1 V the low-side driver lets go; a pull-down must hold the line
      reset_n_oe_o <= live_r;          // R16
      power_fail_warn_out_o <= pf_r;   // R13 R15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic man_low_seen;
  assign man_low_seen = !manual_reset_n_in_i;

  manual_assert_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R07
    man_low_seen [*3] |-> ##[0:3] (reset_o && !reset_n_o))
    else $error("manual reset did not assert outputs in time");

  near3v_assert_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R18
    man_low_seen [*3] |-> ##[0:15] reset_o)
    else $error("manual reset slow beyond 750 ns");

  opposite_pol_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
    $past(!sys_rst_i) |-> (reset_o != reset_n_o))
    else $error("reset outputs not complementary");

  brownout_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R04
    !sup_ok_r |-> ##1 reset_o)
    else $error("low supply did not assert reset");

  source_clear_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
    src_active |=> hold_cnt_r == '0)
    else $error("hold counter not cleared by active source");

  early_release_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R20
    $fell(reset_o) |-> $past(hold_cnt_r) >= CNT_W'(HOLD_CYCLES))
    else $error("reset released before hold completed");

  release_time_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R03
    hold_cnt_r == CNT_W'(HOLD_CYCLES) && !src_active |=> !reset_o && reset_n_o)
    else $error("reset not released at hold expiry");

  pf_follow_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
    pf_sync_r[2] && pf_sync_r[1] |=> ##1 power_fail_warn_out_o)
    else $error("power-fail output not following sense");

  drive_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R16
    !live_r |=> !reset_n_oe_o)
    else $error("reset driver left on below 1 V");

  ////////////////////////////////////////////////////////////////////////
  // checks on the capture filter, the hold counter, the output pair, the power-fail output and the driver enable
  pf_fall_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
    !pf_sync_r[2] && !pf_sync_r[1]
    |=> ##1 !power_fail_warn_out_o)
    else $error("power-fail output not following low sense");

  pf_filter_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R14
    !pf_agree
    |=> $stable(pf_r))
    else $error("power-fail filter took an unconfirmed change");

  sup_filter_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R04
    !sup_agree
    |=> $stable(sup_ok_r))
    else $error("supply filter took an unconfirmed change");

  man_filter_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R11
    !man_agree
    |=> $stable(man_n_r))
    else $error("manual filter took an unconfirmed change");

  live_filter_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R16
    !live_agree
    |=> $stable(live_r))
    else $error("live filter took an unconfirmed change");

  manual_restart_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R08
    $rose(man_n_r) && sup_ok_r
    |-> hold_cnt_r == '0)
    else $error("hold count not fresh at manual release");

  bounce_clear_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R11
    !man_n_r
    |=> hold_cnt_r == '0)
    else $error("manual low did not clear hold count");

  hold_limit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R17
    1'b1
    |-> hold_cnt_r <= CNT_W'(HOLD_CYCLES))
    else $error("hold count ran past its end");

  count_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R02
    !src_active && !hold_done
    |=> hold_cnt_r == $past(hold_cnt_r) + 1'b1)
    else $error("hold count did not advance");

  count_stop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R17
    !src_active && hold_done
    |=> hold_cnt_r == $past(hold_cnt_r))
    else $error("hold count moved after completion");

  hold_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R05
    !hold_done
    |=> reset_o && !reset_n_o)
    else $error("reset released while hold running");

  src_force_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R20
    src_active
    |=> asserted_r && reset_o)
    else $error("active source did not force reset");

  release_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R20
    !reset_o
    |-> $past(!src_active))
    else $error("reset released with a source active");

  fall_pair_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R03
    $fell(reset_o)
    |-> $rose(reset_n_o))
    else $error("reset outputs released apart");

  rise_pair_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
    $rose(reset_o)
    |-> $fell(reset_n_o))
    else $error("reset outputs asserted apart");

  drive_on_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
    live_r
    |=> reset_n_oe_o)
    else $error("reset driver off while supply live");
endmodule : supply_reset_supervisor

// File: host_model.sv
// host processor model on the reset and power-fail outputs
`timescale 1ns/10ps
module host_model (
  input wire logic mclk_i,       // time base
  input wire logic reset_n_i,    // active-low reset level
  input wire logic reset_n_oe_i, // reset driver enable
  input wire logic reset_i,      // active-high reset
  input wire logic warn_i,       // power-fail warning
  output logic held_o,           // host held in reset
  output logic irq_o             // shutdown request seen
);
  logic pin_n;
  // an undriven pin falls to the board pull-down
  assign pin_n = reset_n_oe_i ? reset_n_i : 1'h0;
  assign held_o = !pin_n || reset_i;
  // warn low is taken as the shutdown interrupt
  always_ff @(posedge mclk_i) irq_o <= held_o ? 1'h0 : (irq_o || !warn_i);
endmodule : host_model

// File: supply_reset_supervisor_test.sv
// self-checking bench for the supply reset supervisor
`timescale 1ns/10ps
module supply_reset_supervisor_test;
  import supervisor_pkg::*;
  localparam int unsigned HC = 20; // short hold keeps the run brief
  logic mclk_i = 1'h0, sys_rst_i = 1'h1, ok = 1'h0, live = 1'h0, man_n = 1'h1, sense = 1'h1;
  logic rst_n, oe, rst, warn, held, irq;
  int n_mismatch = 0, total_checks = 0;
  supply_reset_supervisor #(.HOLD_CYCLES(HC)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .supply_ok_i(ok), .supply_live_i(live), .manual_reset_n_in_i(man_n),
    .power_fail_sense_in_i(sense), .reset_n_o(rst_n), .reset_n_oe_o(oe), .reset_o(rst),
    .power_fail_warn_out_o(warn));
  host_model host (.mclk_i(mclk_i), .reset_n_i(rst_n), .reset_n_oe_i(oe), .reset_i(rst),
    .warn_i(warn), .held_o(held), .irq_o(irq));
  initial forever #25 mclk_i = ~mclk_i;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  task automatic chk(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : chk
  // both outputs must show the same state
  task automatic chk_rst(input logic a);
    chk("reset_o", a, rst);
    chk("reset_n_o", !a, rst_n);
  endtask : chk_rst
  task automatic end_of_test();
    $display("total_checks %0d n_mismatch %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic power_up();
    cyc(6);
    sys_rst_i = 1'h0;
    chk("reset_n_oe_o", 1'h0, oe);
    chk_rst(1'h1);
    live = 1'h1;
    ok = 1'h1;
    cyc(HC);
    chk_rst(1'h1);
    cyc(8);
    chk_rst(1'h0);
    chk("reset_n_oe_o", 1'h1, oe);
  endtask : power_up
  task automatic brownout();
    ok = 1'h0;
    cyc(5);
    chk_rst(1'h1);
    ok = 1'h1;
    cyc(10);
    ok = 1'h0;
    cyc(5);
    chk_rst(1'h1);
    ok = 1'h1;
    cyc(HC);
    chk_rst(1'h1);
    cyc(8);
    chk_rst(1'h0);
  endtask : brownout
  task automatic manual_pulse();
    man_n = 1'h0;
    cyc(3);
    man_n = 1'h1;
    cyc(2);
    chk_rst(1'h1);
    cyc(HC);
    chk_rst(1'h1);
    cyc(8);
    chk_rst(1'h0);
  endtask : manual_pulse
  // a second press during the hold must restart the full delay
  task automatic manual_bounce();
    man_n = 1'h0;
    cyc(3);
    man_n = 1'h1;
    cyc(5);
    man_n = 1'h0;
    cyc(3);
    man_n = 1'h1;
    cyc(HC);
    chk_rst(1'h1);
    cyc(8);
    chk_rst(1'h0);
  endtask : manual_bounce
  // one-cycle blips on supply and sense must not get through
  task automatic input_glitch();
    ok = 1'h0;
    sense = 1'h0;
    cyc(1);
    ok = 1'h1;
    sense = 1'h1;
    cyc(6);
    chk_rst(1'h0);
    chk("warn", 1'h1, warn);
    chk("irq", 1'h0, irq);
  endtask : input_glitch
  task automatic power_fail();
    chk("warn", 1'h1, warn);
    sense = 1'h0;
    cyc(6);
    chk("warn", 1'h0, warn);
    chk("irq", 1'h1, irq);
  endtask : power_fail
  task automatic power_down();
    ok = 1'h0;
    cyc(5);
    chk_rst(1'h1);
    live = 1'h0;
    cyc(5);
    chk("reset_n_oe_o", 1'h0, oe);
    chk("held", 1'h1, held);
    chk_rst(1'h1);
  endtask : power_down
  initial begin
    power_up();
    brownout();
    manual_pulse();
    manual_bounce();
    input_glitch();
    power_fail();
    power_down();
    end_of_test();
  end
  // the sequence needs about 180 cycles
  initial begin
    #20_000;
    n_mismatch++;
    end_of_test();
  end
endmodule : supply_reset_supervisor_test
